// ### core/fau_pkg.sv
// Purpose: shared types and constants of the float abs/add unit
// Assumes: single-precision IEEE operands, 3-stage pipeline
// Notes: rounding mode codes are local encodings
package fau_pkg;

  // Issue opcodes
  typedef enum logic [7:0] {
    FAU_ADD = 8'h16,
    FAU_ABS = 8'h73,
    FAU_ABS_FLAGS = 8'h74
  } fau_op_type;

  // Special operand and result patterns
  localparam logic [31:0] FAU_QNAN = 32'h0fffffff;
  localparam logic [31:0] FAU_POS_INF = 32'h7f800000;
  localparam logic [31:0] FAU_ZERO = 32'h00000000;
  localparam logic [7:0] FAU_EXP_MAX = 8'hff;
  localparam logic signed [9:0] FAU_EXP_OVERFLOW = 10'sh0ff;

  // Rounding mode field codes
  localparam logic [1:0] FAU_RM_NEAREST = 2'h0;
  localparam logic [1:0] FAU_RM_POS = 2'h1;
  localparam logic [1:0] FAU_RM_NEG = 2'h2;
  localparam logic [1:0] FAU_RM_ZERO = 2'h3;

  // Result latency in cycles
  localparam int FAU_LATENCY = 3;

  // flag weights
  // Packed from 0x20 down to 0x1; the flag vector result shifts them up to 0x40..0x2 with bit 0x1 zero
  typedef struct packed {
    logic output_flush_zero_flag;
    logic input_flush_zero_flag;
    logic invalid_op_flag;
    logic overflow_flag;
    logic underflow_flag;
    logic inexact_flag;
  } fau_flags_type;

  typedef struct packed {
    logic valid;
    fau_op_type op;
    logic [6:0] dest;
    logic [31:0] a;
    logic [31:0] b;
  } fau_issue_type;

  typedef struct packed {
    logic valid;
    logic [6:0] dest;
    logic [31:0] data;
  } fau_result_type;

  typedef struct packed {
    logic [31:0] data;
    fau_flags_type flags;
  } fau_out_type;

endpackage : fau_pkg

// ### core/fau_unit.sv
// Purpose: float absolute value, its flags variant and float addition
// Assumes: one issue per cycle at most, inputs synchronous to sys_clk
// Notes: holds only the exception bits of the status word
`timescale 1ns/100ps

module fau_unit
  import fau_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fau_issue_type issue,
  input wire logic guard_present,
  input wire logic guard_bit,
  input wire logic [1:0] round_mode,
  input wire logic status_write,
  input wire fau_flags_type status_write_flags,
  input wire fau_flags_type other_flag_updates,
  output fau_result_type result,
  output fau_flags_type exception_flags
);

  // Operand classification
  function automatic logic fau_is_den(input logic [31:0] v);
    return (v[30:23] == 8'h00) && (v[22:0] != 23'h0);
  endfunction : fau_is_den

  function automatic logic fau_is_nan(input logic [31:0] v);
    return (v[30:23] == FAU_EXP_MAX) && (v[22:0] != 23'h0);
  endfunction : fau_is_nan

  function automatic logic fau_is_snan(input logic [31:0] v);
    return fau_is_nan(v) && !v[22];
  endfunction : fau_is_snan

  function automatic logic fau_is_inf(input logic [31:0] v);
    return (v[30:23] == FAU_EXP_MAX) && (v[22:0] == 23'h0);
  endfunction : fau_is_inf

  // Absolute value with its exceptions
  function automatic fau_out_type fau_abs(input logic [31:0] v);
    fau_out_type r;
    r = '0;
    if (fau_is_den(v)) begin
      r.data = FAU_ZERO;
      r.flags.input_flush_zero_flag = 1'b1;
    end else if (fau_is_snan(v)) begin
      r.data = FAU_QNAN;
      r.flags.invalid_op_flag = 1'b1;
    end else if (fau_is_nan(v)) begin
      r.data = v;
    end else begin
      r.data = {1'b0, v[30:0]};
    end
    return r;
  endfunction : fau_abs

  // Sum with rounding and exceptions
  function automatic fau_out_type fau_add(
    input logic [31:0] a,
    input logic [31:0] b,
    input logic [1:0] rm
  );
    fau_out_type r;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] t;
    logic [26:0] mx;
    logic [26:0] my;
    logic [27:0] s;
    logic signed [9:0] e;
    logic [7:0] d;
    logic sg;
    logic inc;
    logic lost;
    r = '0;
    x = a;
    y = b;
    inc = 1'b0;
    if (fau_is_den(x)) begin
      x = {x[31], 31'h0};
      r.flags.input_flush_zero_flag = 1'b1;
    end
    if (fau_is_den(y)) begin
      y = {y[31], 31'h0};
      r.flags.input_flush_zero_flag = 1'b1;
    end
    if (fau_is_nan(x) || fau_is_nan(y)) begin
      r.data = FAU_QNAN;
      r.flags.invalid_op_flag = fau_is_snan(x) | fau_is_snan(y);
    end else if (fau_is_inf(x) && fau_is_inf(y) && (x[31] != y[31])) begin
      r.data = FAU_QNAN;
      r.flags.invalid_op_flag = 1'b1;
    end else if (fau_is_inf(x)) begin
      r.data = x;
    end else if (fau_is_inf(y)) begin
      r.data = y;
    end else begin
      // Larger magnitude first
      if (y[30:0] > x[30:0]) begin
        t = x;
        x = y;
        y = t;
      end
      mx = (x[30:23] == 8'h00) ? 27'h0 : {1'b1, x[22:0], 3'h0};
      my = (y[30:23] == 8'h00) ? 27'h0 : {1'b1, y[22:0], 3'h0};
      d = x[30:23] - y[30:23];
      // Align with sticky collection
      if (d > 8'd26) begin
        my = {26'h0, |my};
      end else begin
        lost = |(my & ((27'h1 << d) - 27'h1));
        my = (my >> d) | {26'h0, lost};
      end
      e = signed'({2'b00, x[30:23]});
      sg = x[31];
      if (x[31] == y[31]) begin
        s = {1'b0, mx} + {1'b0, my};
      end else begin
        s = {1'b0, mx} - {1'b0, my};
      end
      // Normalise
      if (s[27]) begin
        s = {1'b0, s[27:2], s[1] | s[0]};
        e = e + 10'sd1;
      end else begin
        for (int i = 0; i < 26; i++) begin
          if (!s[26] && (s != 28'h0)) begin
            s = s << 1;
            e = e - 10'sd1;
          end
        end
      end
      if (s == 28'h0) begin
        r.data = FAU_ZERO;
      end else begin
        lost = |s[2:0];
        case (rm)
          FAU_RM_NEAREST: inc = s[2] & (s[1] | s[0] | s[3]);
          FAU_RM_POS: inc = lost & !sg;
          FAU_RM_NEG: inc = lost & sg;
          default: inc = 1'b0;
        endcase
        s = s + {24'h0, inc, 3'h0};
        if (s[27]) begin
          s = s >> 1;
          e = e + 10'sd1;
        end
        r.flags.inexact_flag = lost;
        if (e >= FAU_EXP_OVERFLOW) begin
          r.data = FAU_POS_INF;
          r.flags.overflow_flag = 1'b1;
          r.flags.inexact_flag = 1'b1;
        end else if (e <= 10'sd0) begin
          r.data = FAU_ZERO;
          r.flags.output_flush_zero_flag = 1'b1;
          r.flags.underflow_flag = 1'b1;
          r.flags.inexact_flag = 1'b1;
        end else begin
          r.data = {sg, e[7:0], s[25:3]};
        end
      end
    end
    return r;
  endfunction : fau_add

  fau_issue_type st1;
  logic [1:0] st1_rm;
  fau_op_type st2_op;
  logic st2_valid;
  logic [6:0] st2_dest;
  fau_out_type st2_out;
  fau_out_type calc;
  fau_out_type abs_calc;
  logic st1_take;
  logic st2_sets;
  fau_flags_type next_flags;

  assign st1_take = issue.valid && (!guard_present || guard_bit);

  // Stage 1: capture issued operation
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st1 <= '0;
      st1_rm <= FAU_RM_NEAREST;
    end else begin
      st1 <= issue;
      st1.valid <= st1_take;
      st1_rm <= round_mode;
    end
  end

  // Compute selected operation
  always_comb begin
    calc = '0;
    abs_calc = fau_abs(st1.a);
    case (st1.op)
      FAU_ABS: calc = abs_calc;
      FAU_ADD: calc = fau_add(st1.a, st1.b, st1_rm);
      FAU_ABS_FLAGS: begin
        calc.data = {25'h0, abs_calc.flags, 1'b0};
      end
      default: calc = '0;
    endcase
  end

  // Stage 2: hold computed value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st2_valid <= 1'b0;
      st2_op <= FAU_ADD;
      st2_dest <= 7'h00;
      st2_out <= '0;
    end else begin
      st2_valid <= st1.valid && (st1.op inside {FAU_ABS, FAU_ADD, FAU_ABS_FLAGS});
      st2_op <= st1.op;
      st2_dest <= st1.dest;
      st2_out <= calc;
    end
  end

  // third stage drives result
  // Stage 3: destination write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= '0;
    end else begin
      result.valid <= st2_valid;
      result.dest <= st2_dest;
      result.data <= st2_out.data;
    end
  end

  assign st2_sets = st2_valid && (st2_op != FAU_ABS_FLAGS);

  always_comb begin
    next_flags = status_write ? status_write_flags : exception_flags;
    next_flags = next_flags | other_flag_updates;
    if (st2_sets) begin
      next_flags = next_flags | st2_out.flags;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      exception_flags <= '0;
    end else begin
      exception_flags <= next_flags;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_abs_mag;
    logic [31:0] v;
    (st1_take && issue.op == FAU_ABS && issue.a[30:23] != 8'h00
      && issue.a[30:23] != FAU_EXP_MAX, v = issue.a)
      |-> ##3 result.valid && result.data == {1'b0, v[30:0]};
  endproperty

  abs_magnitude_a: assert property (p_abs_mag)
    else $error("abs result wrong or late");

  abs_flush_a: assert property (
    st1_take && issue.op == FAU_ABS && fau_is_den(issue.a)
      |-> ##3 result.data == FAU_ZERO && exception_flags.input_flush_zero_flag)
    else $error("denormal abs not flushed");

  abs_snan_a: assert property (
    st1_take && issue.op == FAU_ABS && fau_is_snan(issue.a)
      |-> ##3 result.data == FAU_QNAN && exception_flags.invalid_op_flag)
    else $error("signalling NaN abs wrong");

  flags_sticky_a: assert property (
    !status_write |=> (($past(exception_flags) & ~exception_flags) == 6'h00))
    else $error("flag dropped without write");

  flags_merge_a: assert property (
    1'b1 |=> ((exception_flags & $past(other_flag_updates))
      == $past(other_flag_updates)))
    else $error("concurrent update lost");

  guard_block_a: assert property (
    issue.valid && guard_present && !guard_bit |-> ##3 !result.valid)
    else $error("guarded op wrote result");

  flags_quiet_a: assert property (
    !status_write && other_flag_updates == 6'h00 && !st2_sets
      |=> $stable(exception_flags))
    else $error("flags changed without cause");

  flag_vector_a: assert property (
    st1_take && issue.op == FAU_ABS_FLAGS && fau_is_den(issue.a)
      |-> ##3 result.valid && result.data == 32'h00000020)
    else $error("flag vector wrong");

  add_latency_a: assert property (
    st1_take && issue.op == FAU_ADD |-> ##3 result.valid)
    else $error("sum not delivered on time");

  add_infs_a: assert property (
    st1_take && issue.op == FAU_ADD && issue.a == FAU_POS_INF
      && issue.b == {1'b1, FAU_POS_INF[30:0]}
      |-> ##3 result.data == FAU_QNAN && exception_flags.invalid_op_flag)
    else $error("inf minus inf wrong");

  abs_issue_c: cover property (st1_take && issue.op == FAU_ABS ##3 result.valid);
  add_overflow_c: cover property (st2_sets && st2_out.flags.overflow_flag);
  add_flush_c: cover property (st2_sets && st2_out.flags.output_flush_zero_flag);
  guard_off_c: cover property (issue.valid && guard_present && !guard_bit);

endmodule : fau_unit

// ### verification/fau_regfile_model.sv
// Purpose: register file that takes the unit's destination writes
// Assumes: one result write per cycle, 128 registers
// Notes: registers start with a per-index pattern so skipped writes show
`timescale 1ns/100ps

module fau_regfile_model
  import fau_pkg::*;
(
  input wire logic sys_clk,
  input wire fau_result_type result
);

  logic [31:0] mem [128];

  // Distinct start values, never a legal result of the tests
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 32'h5a5a0000 | i;
    end
  end

  // Destination write on each result pulse
  always @(posedge sys_clk) begin
    if (result.valid === 1'b1) begin
      mem[result.dest] <= result.data;
    end
  end

endmodule : fau_regfile_model

// ### verification/tb_top.sv
// Purpose: self-checking bench of the float abs/add unit
// Assumes: one operation in flight at a time, inputs driven at falling edge
// Notes: other-unit flag sets are pulsed in the result cycle of an operation
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_top;
  import fau_pkg::*;

  logic sys_clk;
  logic rst_b;
  fau_issue_type issue;
  logic guard_present;
  logic guard_bit;
  logic [1:0] round_mode;
  logic status_write;
  fau_flags_type status_write_flags;
  fau_flags_type other_flag_updates;
  fau_result_type result;
  fau_flags_type exception_flags;
  fau_flags_type exp_fl;
  fau_flags_type oth;
  logic [6:0] dest_n;
  int err_total = 0;
  int comparisons = 0;

  fau_unit uut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .issue(issue),
    .guard_present(guard_present),
    .guard_bit(guard_bit),
    .round_mode(round_mode),
    .status_write(status_write),
    .status_write_flags(status_write_flags),
    .other_flag_updates(other_flag_updates),
    .result(result),
    .exception_flags(exception_flags)
  );

  fau_regfile_model rf (
    .sys_clk(sys_clk),
    .result(result)
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic end_sim;
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // One issue, then result and flags checked at exactly the third edge
  task automatic op(input fau_op_type o, input logic [31:0] a, input logic [31:0] b,
    input logic [1:0] g, input logic [31:0] ed, input fau_flags_type ef);
    logic ev;
    ev = !(g[1] && !g[0]);
    @(negedge sys_clk);
    issue = '{1'b1, o, dest_n, a, b};
    guard_present = g[1];
    guard_bit = g[0];
    @(negedge sys_clk);
    issue.valid = 1'b0;
    // Result lands on the second edge after the one that takes the issue
    @(negedge sys_clk);
    `CHK("early valid", 1'b0, result.valid)
    `CHK("early flags", exp_fl, exception_flags)
    other_flag_updates = oth;
    @(negedge sys_clk);
    other_flag_updates = 6'h00;
    if (ev && o != FAU_ABS_FLAGS) begin
      exp_fl = exp_fl | ef;
    end
    exp_fl = exp_fl | oth;
    oth = 6'h00;
    `CHK("result valid", ev, result.valid)
    `CHK("flags", exp_fl, exception_flags)
    if (ev) begin
      `CHK("result dest", dest_n, result.dest)
      `CHK("result data", ed, result.data)
    end else begin
      `CHK("reg kept", 32'h5a5a0000 | dest_n, rf.mem[dest_n])
    end
    dest_n++;
  endtask : op

  // Explicit status write of the exception bits
  task automatic wr_status(input fau_flags_type v);
    @(negedge sys_clk);
    status_write = 1'b1;
    status_write_flags = v;
    @(negedge sys_clk);
    status_write = 1'b0;
    exp_fl = v;
    `CHK("status write", v, exception_flags)
  endtask : wr_status

  // Hang guard, far beyond the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    issue = '0;
    guard_present = 1'b0;
    guard_bit = 1'b0;
    round_mode = FAU_RM_NEAREST;
    status_write = 1'b0;
    status_write_flags = 6'h00;
    other_flag_updates = 6'h00;
    exp_fl = 6'h00;
    oth = 6'h00;
    dest_n = 7'h00;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    op(FAU_ABS, 32'h40400000, 32'h0, 2'h0, 32'h40400000, 6'h00);
    op(FAU_ABS, 32'hbf800000, 32'h0, 2'h0, 32'h3f800000, 6'h00);
    op(FAU_ABS, 32'h00400000, 32'h0, 2'h0, 32'h00000000, 6'h10);
    op(FAU_ABS, 32'h0fffffff, 32'h0, 2'h0, 32'h0fffffff, 6'h00);
    op(FAU_ABS, 32'hffffffff, 32'h0, 2'h0, 32'hffffffff, 6'h00);
    op(FAU_ABS, 32'hffbfffff, 32'h0, 2'h0, 32'h0fffffff, 6'h08);
    wr_status(6'h00);
    op(FAU_ABS, 32'hffbfffff, 32'h0, 2'h2, 32'h0, 6'h08);
    op(FAU_ABS, 32'hff7fffff, 32'h0, 2'h3, 32'h7f7fffff, 6'h00);
    op(FAU_ABS_FLAGS, 32'h00400000, 32'h0, 2'h0, 32'h00000020, 6'h00);
    op(FAU_ABS_FLAGS, 32'hffbfffff, 32'h0, 2'h0, 32'h00000010, 6'h00);
    op(FAU_ABS_FLAGS, 32'hff7fffff, 32'h0, 2'h3, 32'h00000000, 6'h00);
    op(FAU_ABS_FLAGS, 32'h00400000, 32'h0, 2'h2, 32'h0, 6'h00);
    op(FAU_ADD, 32'hc0400000, 32'h3f800000, 2'h0, 32'hc0000000, 6'h00);
    op(FAU_ADD, 32'h40400000, 32'hc0400000, 2'h0, 32'h00000000, 6'h00);
    op(FAU_ADD, 32'h7f7fffff, 32'h7f7fffff, 2'h2, 32'h0, 6'h05);
    oth = 6'h02;
    op(FAU_ADD, 32'h40400000, 32'h00400000, 2'h3, 32'h40400000, 6'h10);
    op(FAU_ADD, 32'h00c00000, 32'h80800000, 2'h0, 32'h00000000, 6'h23);
    op(FAU_ADD, 32'h7f800000, 32'hff800000, 2'h0, 32'h0fffffff, 6'h08);
    wr_status(6'h3f);
    wr_status(6'h00);
    op(FAU_ADD, 32'h7f7fffff, 32'h7f7fffff, 2'h0, 32'h7f800000, 6'h05);
    op(FAU_ADD, 32'h00800000, 32'h00800000, 2'h0, 32'h01000000, 6'h00);
    // Tiny addend: +3.0 rounds up only toward +inf; -3.0 goes to 0xc03fffff toward +inf and toward zero
    for (int m = 0; m < 4; m++) begin
      round_mode = m[1:0];
      op(FAU_ADD, 32'h40400000, 32'h00800000, 2'h0,
        (m == 1) ? 32'h40400001 : 32'h40400000, 6'h01);
      op(FAU_ADD, 32'hc0400000, 32'h00800000, 2'h0,
        m[0] ? 32'hc03fffff : 32'hc0400000, 6'h01);
    end
    end_sim();
  end

endmodule : tb_top
